// ===== hdl/dsic_defs.svh
// constants for the strobe-driven input capture cell
`ifndef DSIC_DEFS_SVH
`define DSIC_DEFS_SVH

// width of one pad data word carried in a captured pair
`define DSIC_DATA_W 8

// configured initial value of a register: reset or set
`define DSIC_INIT_RESET 1'b0
`define DSIC_INIT_SET 1'b1

// sync_clock_polarity encodings
`define DSIC_POL_TRUE 1'b0
`define DSIC_POL_INVERTED 1'b1

// static input mode encodings
`define DSIC_MODE_PLAIN 1'b0
`define DSIC_MODE_DDR_MEM 1'b1

// synchroniser idle levels
`define DSIC_LEVEL_LOW 1'b0

`endif

// ===== hdl/dsic_pkg.sv
// types shared by the strobe-driven input capture cell
`include "dsic_defs.svh"

package dsic_pkg;

    typedef logic [`DSIC_DATA_W-1:0] dsic_word_t;

    // one beat: word taken on the strobe rise and the word taken on its fall
    typedef struct packed {
        dsic_word_t rise;
        dsic_word_t fall;
    } dsic_pair_t;

    // capture sequencer, one-hot
    typedef enum logic [1:0] {
        DSIC_WAIT_RISE = 2'b01,
        DSIC_WAIT_FALL = 2'b10
    } dsic_state_t;

endpackage : dsic_pkg

// ===== hdl/dsic_capture.sv
// strobe-driven input capture cell with system-clock retiming
`timescale 1ns/1ns
`include "dsic_defs.svh"

module dsic_capture #(
    parameter int DATA_W = `DSIC_DATA_W,
    // configured initial values of the capture and retiming registers
    parameter logic INIT_RISE = `DSIC_INIT_RESET,
    parameter logic INIT_FALL = `DSIC_INIT_RESET,
    parameter logic INIT_OUT_RISE = `DSIC_INIT_RESET,
    parameter logic INIT_OUT_FALL = `DSIC_INIT_RESET
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // static configuration
    input wire logic ddr_mem_mode,
    // from the strobe read/write logic
    input wire logic shifted_read_strobe,
    input wire logic sync_clock_polarity,
    // pad data from the external memory
    input wire logic [DATA_W-1:0] pad_data,
    // to the core
    output logic [DATA_W-1:0] core_rise,
    output logic [DATA_W-1:0] core_fall,
    output logic core_valid,
    output logic mode_is_ddr_mem
);

    ////////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    // the packed pair fixes the word width; another width needs a new package
    if (DATA_W != `DSIC_DATA_W) begin : g_width_check
        $error("DATA_W must equal the packed pair word width");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // a configured set fills the word with ones, a reset with zeros
    function automatic dsic_pkg::dsic_word_t dsic_init_word(input logic set_value);
        dsic_init_word = {DATA_W{set_value}};
    endfunction : dsic_init_word

    function automatic dsic_pkg::dsic_pair_t dsic_init_pair(input logic set_rise, input logic set_fall);
        dsic_init_pair.rise = dsic_init_word(set_rise);
        dsic_init_pair.fall = dsic_init_word(set_fall);
    endfunction : dsic_init_pair

    ////////////////////////////////////////////////////////////////////////////////
    // static mode, caught while reset is held

    logic mode_s1;
    logic mode_ddr;

    // strap passes a first flop before the latch, as any pin does
    always_ff @(posedge clk) begin
        mode_s1 <= ddr_mem_mode;
    end

    // sampled only under reset so a toggling pin cannot switch modes mid-stream
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_ddr <= mode_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // synchronisers for strobe, polarity and pad data
    // limitation: strobe levels shorter than one system cycle can be lost

    logic strobe_s1;
    logic strobe_s2;
    logic strobe_s3;
    logic pol_s1;
    logic pol_s2;
    dsic_pkg::dsic_word_t data_s1;
    dsic_pkg::dsic_word_t data_s2;

    always_ff @(posedge clk) begin
        if (rst) begin
            strobe_s1 <= `DSIC_LEVEL_LOW;
            strobe_s2 <= `DSIC_LEVEL_LOW;
            strobe_s3 <= `DSIC_LEVEL_LOW;
            pol_s1 <= `DSIC_POL_TRUE;
            pol_s2 <= `DSIC_POL_TRUE;
            data_s1 <= '0;
            data_s2 <= '0;
        end else begin
            strobe_s1 <= shifted_read_strobe;
            strobe_s2 <= strobe_s1;
            strobe_s3 <= strobe_s2;
            pol_s1 <= sync_clock_polarity;
            pol_s2 <= pol_s1;
            data_s1 <= pad_data;
            data_s2 <= data_s1;
        end
    end

    // data and strobe pass equal stages, so the edge sees the word it framed
    wire strobe_rise = strobe_s2 & ~strobe_s3;
    wire strobe_fall = ~strobe_s2 & strobe_s3;

    ////////////////////////////////////////////////////////////////////////////////
    // capture sequencer: a fall pairs only with a rise seen before it

    dsic_pkg::dsic_state_t state;
    dsic_pkg::dsic_state_t next_state;

    always_comb begin
        next_state = state;
        // reset keeps the state on its two codes, so no default arm
        unique case (state)
            dsic_pkg::DSIC_WAIT_RISE: begin
                if (strobe_rise) begin
                    next_state = dsic_pkg::DSIC_WAIT_FALL;
                end
            end
            dsic_pkg::DSIC_WAIT_FALL: begin
                if (strobe_fall) begin
                    next_state = dsic_pkg::DSIC_WAIT_RISE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst || mode_ddr != `DSIC_MODE_DDR_MEM) begin
            state <= dsic_pkg::DSIC_WAIT_RISE;
        end else begin
            state <= next_state;
        end
    end

    wire ddr_active = (mode_ddr == `DSIC_MODE_DDR_MEM);
    wire take_rise = ddr_active & strobe_rise;
    wire take_fall = ddr_active & strobe_fall & (state == dsic_pkg::DSIC_WAIT_FALL);

    ////////////////////////////////////////////////////////////////////////////////
    // strobe-domain capture registers

    // each half holds until its own edge comes again, so the pair stays whole
    dsic_pkg::dsic_pair_t captured;

    always_ff @(posedge clk) begin
        if (rst) begin
            captured <= dsic_init_pair(INIT_RISE, INIT_FALL);
        end else begin
            if (take_rise) begin
                captured.rise <= data_s2;
            end
            if (take_fall) begin
                captured.fall <= data_s2;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // retiming onto the system clock

    // inverted phase is modelled as one extra system cycle of settling;
    // the strobe half period spans several cycles, so the pair is still stable
    // trade-off: one clock keeps timing simple but costs a cycle on that phase
    logic beat_d1;
    logic beat_d2;

    always_ff @(posedge clk) begin
        if (rst) begin
            beat_d1 <= `DSIC_LEVEL_LOW;
            beat_d2 <= `DSIC_LEVEL_LOW;
        end else begin
            beat_d1 <= take_fall;
            beat_d2 <= beat_d1;
        end
    end

    wire load_ddr = (pol_s2 == `DSIC_POL_INVERTED) ? beat_d2 : beat_d1;
    wire load_plain = ~ddr_active;

    ////////////////////////////////////////////////////////////////////////////////
    // core-facing registers

    // plain mode leaves the fall word at its configured value
    dsic_pkg::dsic_pair_t retimed;

    always_ff @(posedge clk) begin
        if (rst) begin
            retimed <= dsic_init_pair(INIT_OUT_RISE, INIT_OUT_FALL);
            core_valid <= `DSIC_LEVEL_LOW;
        end else begin
            core_valid <= load_ddr | load_plain;
            if (load_ddr) begin
                retimed <= captured;
            end else if (load_plain) begin
                // ordinary input register: one word per system clock
                retimed.rise <= data_s2;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_is_ddr_mem <= `DSIC_MODE_PLAIN;
        end else begin
            mode_is_ddr_mem <= mode_ddr;
        end
    end

    // outputs are the retiming flops themselves, no logic after them
    assign core_rise = retimed.rise;
    assign core_fall = retimed.fall;

endmodule : dsic_capture

// ===== tb/dsic_capture_assertions.sv
// checker for the strobe capture cell
`timescale 1ns/1ns
module dsic_capture_assertions (
    // watched ports
    input wire logic clk,
    input wire logic rst,
    input wire logic ddr_mem_mode,
    input wire logic shifted_read_strobe,
    input wire logic sync_clock_polarity,
    input wire logic [7:0] pad_data,
    input wire logic [7:0] core_rise,
    input wire logic [7:0] core_fall,
    input wire logic core_valid,
    input wire logic mode_is_ddr_mem
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // clock cycles seen since release, saturating at 7
    logic [2:0] run;
    always_ff @(posedge clk) begin
        if (rst) begin
            run <= 3'h0;
        end else if (run != 3'h7) begin
            run <= run + 3'h1;
        end
    end
    ////////////////////////////////////////////////////////////
    sequence s_fall;
        $fell(shifted_read_strobe) ##0 mode_is_ddr_mem && run == 3'h7;
    endsequence
    property p_init;
        $fell(rst) |-> core_rise == 8'h00 && core_fall == 8'h00 && !core_valid;
    endproperty
    property p_mode;
        $fell(rst) |=> mode_is_ddr_mem == $past(ddr_mem_mode, 3);
    endproperty
    property p_fixed;
        !$past(rst) |=> $stable(mode_is_ddr_mem);
    endproperty
    property p_plain_valid;
        !mode_is_ddr_mem && run != 3'h0 |-> core_valid;
    endproperty
    property p_plain_data;
        !mode_is_ddr_mem && run >= 3'h3 |-> core_rise == $past(pad_data, 3);
    endproperty
    property p_pulse;
        mode_is_ddr_mem && core_valid |=> !core_valid;
    endproperty
    property p_pol0;
        s_fall ##0 !sync_clock_polarity |-> ##[3:5] core_valid;
    endproperty
    property p_pol1;
        s_fall ##0 sync_clock_polarity |-> ##[4:6] core_valid;
    endproperty
    property p_hold;
        mode_is_ddr_mem && !core_valid && run == 3'h7 |-> $stable(core_rise) && $stable(core_fall);
    endproperty
    a_init: assert property (p_init) else $error("outputs not at initial value");
    a_mode: assert property (p_mode) else $error("mode not latched");
    a_fixed: assert property (p_fixed) else $error("mode moved");
    a_plain_valid: assert property (p_plain_valid) else $error("plain valid low");
    a_plain_data: assert property (p_plain_data) else $error("plain data wrong");
    a_pulse: assert property (p_pulse) else $error("valid too long");
    a_pol0: assert property (p_pol0) else $error("true phase late");
    a_pol1: assert property (p_pol1) else $error("inverted phase late");
    a_hold: assert property (p_hold) else $error("pair moved");
endmodule : dsic_capture_assertions
bind dsic_capture dsic_capture_assertions chk_u (.clk(clk), .rst(rst), .ddr_mem_mode(ddr_mem_mode),
    .shifted_read_strobe(shifted_read_strobe), .sync_clock_polarity(sync_clock_polarity),
    .pad_data(pad_data), .core_rise(core_rise), .core_fall(core_fall), .core_valid(core_valid),
    .mode_is_ddr_mem(mode_is_ddr_mem));

// ===== tb/dsic_mem_model.sv
// memory driving strobe and data
`timescale 1ns/1ns
module dsic_mem_model (
    // towards the cell
    output logic strobe,
    output logic [7:0] dq
);
    initial begin
        strobe = 1'h0;
        dq = 8'h5A;
    end
    // data settles 100 ns around each strobe edge; strobe idles low
    task automatic send_pair(input logic [7:0] r, input logic [7:0] f);
        #10 dq = r;
        #100 strobe = 1'h1;
        #100 dq = f;
        #100 strobe = 1'h0;
        #200 dq = ~f;
    endtask : send_pair
endmodule : dsic_mem_model

// ===== tb/dsic_capture_tb.sv
// testbench for the strobe capture cell
`timescale 1ns/1ns
module dsic_capture_tb;
    logic clk;
    logic rst;
    logic mode;
    logic sel;
    logic pol;
    logic [7:0] pin;
    logic strobe;
    logic [7:0] dq;
    logic [7:0] rise;
    logic [7:0] fall;
    logic valid;
    logic mode_q;
    int bad_count;
    int tests_run;
    int cycles = 0;
    dsic_capture dut_u (.clk(clk), .rst(rst), .ddr_mem_mode(mode), .shifted_read_strobe(strobe),
        .sync_clock_polarity(pol), .pad_data(sel ? dq : pin), .core_rise(rise), .core_fall(fall),
        .core_valid(valid), .mode_is_ddr_mem(mode_q));
    dsic_mem_model mem_u (.strobe(strobe), .dq(dq));
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        if (bad_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    task automatic do_reset(input logic m);
        rst <= 1'h1;
        mode <= m;
        sel <= m;
        repeat (20) @(posedge clk);
        check(rise, 8'h00);
        check(fall, 8'h00);
        check({7'h0, valid}, 8'h00);
        check({7'h0, mode_q}, 8'h00);
        rst <= 1'h0;
        @(posedge clk);
    endtask : do_reset
    task automatic plain_run();
        do_reset(1'h0);
        for (int i = 0; i < 6; i++) begin
            pin <= 8'h30 + 8'(i);
            @(posedge clk);
        end
        #1;
        check(rise, 8'h33);
        check(fall, 8'h00);
        check({6'h0, valid, mode_q}, 8'h02);
    endtask : plain_run
    task automatic pair_run(input logic p, input logic [7:0] r, input logic [7:0] f, output int lat);
        @(posedge clk);
        pol <= p;
        repeat (4) @(posedge clk);
        fork
            mem_u.send_pair(r, f);
            begin
                @(negedge strobe);
                lat = 0;
                while (valid !== 1'h1 && lat < 20) begin
                    @(posedge clk);
                    #1;
                    lat++;
                end
            end
        join
        check(rise, r);
        check(fall, f);
    endtask : pair_run
    task automatic ddr_run();
        int lat0;
        int lat1;
        @(posedge clk);
        do_reset(1'h1);
        // strap change outside reset is ignored
        mode <= 1'h0;
        pair_run(1'h0, 8'hA5, 8'h3C, lat0);
        pair_run(1'h1, 8'h96, 8'h0F, lat1);
        check(8'(lat1 - lat0), 8'h01);
        check({7'h0, mode_q}, 8'h01);
    endtask : ddr_run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        rst = 1'h1;
        mode = 1'h0;
        sel = 1'h0;
        pol = 1'h0;
        pin = 8'h00;
        bad_count = 0;
        tests_run = 0;
        plain_run();
        ddr_run();
        complete_run();
    end
endmodule : dsic_capture_tb
